// ---- core/bbc_converter.sv ----
// signed converter between packed decimal digits and plain binary
// assumes operand and direction are synchronous to CORE_CLK_I
//
// Summary of operation
// - digits above nine decode as nine
// - decode: packed digits become binary magnitude
// - top bit is sign, carried over unchanged
// - decode above limit gives 9999999
// - decode below negative limit gives -9999999
// - encode: binary magnitude becomes packed digits
// - encode above 9999999 gives seven nine-digits
// - encode below -9999999 gives negative nine-digits
// - disabled converter clears, result held zero
// - direction selects decode or encode; decode default
`timescale 1ns/1ps

module bbc_converter (
	input  wire logic               CORE_CLK_I,
	input  wire logic               SYS_RST_I,
	input  wire logic               CONV_ENABLE_I,
	input  wire logic               ENCODE_DIRECTION_I,
	input  wire bbc_pkg::bbc_word_t CONV_OPERAND_IN_I,
	output      bbc_pkg::bbc_word_t CONV_RESULT_OUT_O
);

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [bbc_pkg::DIGIT_W-1:0] clamp_digit(
		input logic [bbc_pkg::DIGIT_W-1:0] d
	);
		clamp_digit = (d > bbc_pkg::DIGIT_MAX) ? bbc_pkg::DIGIT_MAX : d;
	endfunction

	// clamping before weighting keeps an invalid digit from carrying upward
	function automatic logic [bbc_pkg::MAG_W-1:0] bcd_to_bin(
		input logic [bbc_pkg::BCD_W-1:0] bcd
	);
		logic [bbc_pkg::MAG_W-1:0] acc;
		acc = '0;
		for (int i = bbc_pkg::NUM_DIGITS - 1; i >= 0; i--)
		begin
			acc = bbc_pkg::MAG_W'(acc * 31'h0000000a) +
				bbc_pkg::MAG_W'(clamp_digit(bcd[i*bbc_pkg::DIGIT_W +: bbc_pkg::DIGIT_W]));
		end
		bcd_to_bin = acc;
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	bbc_pkg::bbc_state_t       state_ff;
	bbc_pkg::bbc_state_t       nxt_state;
	logic [bbc_pkg::BCD_W-1:0] enc_digits;

	// the encoder only sees the low bits; larger magnitudes saturate anyway
	bbc_bin2bcd u_bin2bcd (
		.bin_i (CONV_OPERAND_IN_I.mag[bbc_pkg::BIN_W-1:0]),
		.bcd_o (enc_digits)
	);

	// ****************************************************************
	// next-state logic
	// ****************************************************************
	always_comb
	begin
		nxt_state = state_ff;
		if (!CONV_ENABLE_I)
		begin
			nxt_state.result = bbc_pkg::RESULT_RST;
			nxt_state.sat    = 1'h0;
		end
		else if (ENCODE_DIRECTION_I == bbc_pkg::DIR_DECODE)
		begin
			// recomputed each cycle, no hold of earlier results
			// saturation keeps the input sign, so both limits mirror each other
			nxt_state.result.sign = CONV_OPERAND_IN_I.sign;
			if (CONV_OPERAND_IN_I.mag > bbc_pkg::DEC_LIMIT)
			begin
				nxt_state.result.mag = bbc_pkg::DEC_SAT;
				nxt_state.sat        = 1'h1;
			end
			else
			begin
				nxt_state.result.mag = bcd_to_bin(CONV_OPERAND_IN_I.mag[bbc_pkg::BCD_W-1:0]);
				nxt_state.sat        = 1'h0;
			end
		end
		else
		begin
			nxt_state.result.sign = CONV_OPERAND_IN_I.sign;
			if (CONV_OPERAND_IN_I.mag > bbc_pkg::ENC_LIMIT)
			begin
				nxt_state.result.mag = bbc_pkg::ENC_SAT;
				nxt_state.sat        = 1'h1;
			end
			else
			begin
				nxt_state.result.mag = {{(bbc_pkg::MAG_W-bbc_pkg::BCD_W){1'h0}}, enc_digits};
				nxt_state.sat        = 1'h0;
			end
		end
	end

	always_ff @(posedge CORE_CLK_I)
	begin
		if (SYS_RST_I)
		begin
			state_ff.result <= bbc_pkg::RESULT_RST;
			state_ff.sat    <= 1'h0;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	assign CONV_RESULT_OUT_O = state_ff.result;

	// ****************************************************************
	// checks
	// ****************************************************************
	// one-cycle latency: each check relates the operand to the next output
	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (SYS_RST_I);
	// the sat flag is internal; it only feeds the checks and covers

	logic                      en;
	logic                      dec;
	bbc_pkg::bbc_word_t        op;
	bbc_pkg::bbc_word_t        res;
	assign en  = CONV_ENABLE_I;
	assign dec = (ENCODE_DIRECTION_I == bbc_pkg::DIR_DECODE);
	assign op  = CONV_OPERAND_IN_I;
	assign res = state_ff.result;

	off_zero_a: assert property (!en |=> res == bbc_pkg::RESULT_RST)
		else $error("result not zero while disabled");

	sign_keep_a: assert property (en |=> res.sign == $past(op.sign))
		else $error("sign bit not carried over");

	dec_sat_pos_a: assert property (en && dec && !op.sign && op.mag > 31'h09999999
		|=> res == {1'h0, 31'h0098967f})
		else $error("decode positive saturation wrong");

	dec_sat_neg_a: assert property (en && dec && op.sign && op.mag > 31'h09999999
		|=> res == {1'h1, 31'h0098967f})
		else $error("decode negative saturation wrong");

	dec_clamp_a: assert property (en && dec && op.mag <= 31'h09999999 && op.mag[3:0] > 4'h9
		|=> res.mag % 31'h0000000a == 31'h00000009)
		else $error("invalid digit not read as nine");

	dec_digits_a: assert property (en && dec && op.mag <= 31'h09999999
		|=> (res.mag / 31'h0000000a) % 31'h0000000a ==
			(($past(op.mag[7:4]) > 4'h9) ? 31'h00000009 : 31'($past(op.mag[7:4]))))
		else $error("decoded tens digit wrong");

	enc_sat_pos_a: assert property (en && !dec && !op.sign && op.mag > 31'h0098967f
		|=> res == {1'h0, 31'h09999999})
		else $error("encode positive saturation wrong");

	enc_sat_neg_a: assert property (en && !dec && op.sign && op.mag > 31'h0098967f
		|=> res == {1'h1, 31'h09999999})
		else $error("encode negative saturation wrong");

	enc_digits_a: assert property (en && !dec && op.mag <= 31'h0098967f
		|=> res.mag[3:0] == 4'($past(op.mag) % 31'h0000000a) && res.mag <= 31'h09999999)
		else $error("encoded low digit wrong");

	dir_low_a: assert property (en && !ENCODE_DIRECTION_I && op.mag == 31'h00000010
		|=> res.mag == 31'h0000000a)
		else $error("low direction does not decode");

	recompute_a: assert property (en ##1 en && op != $past(op) && op.mag == 31'h0
		|=> res.mag == 31'h0 && res.sign == $past(op.sign))
		else $error("result not refreshed from new operand");

	// ****************************************************************
	// further digit, range, direction and disable checks, and covers
	// ****************************************************************
	dec_units_a: assert property (en && dec && op.mag <= 31'h09999999 && op.mag[3:0] <= 4'h9
		|=> res.mag % 31'h0000000a == 31'($past(op.mag[3:0])))
		else $error("decoded units digit wrong");

	dec_thou_clamp_a: assert property (en && dec && op.mag <= 31'h09999999 && op.mag[15:12] > 4'h9
		|=> (res.mag / 31'h000003e8) % 31'h0000000a == 31'h00000009)
		else $error("invalid thousands digit not read as nine");

	dec_range_a: assert property (en && dec
		|=> res.mag <= 31'h0098967f)
		else $error("decoded magnitude above full scale");

	enc_tens_a: assert property (en && !dec && op.mag <= 31'h0098967f
		|=> res.mag[7:4] == 4'(($past(op.mag) / 31'h0000000a) % 31'h0000000a))
		else $error("encoded tens digit wrong");

	enc_hund_a: assert property (en && !dec && op.mag <= 31'h0098967f
		|=> res.mag[11:8] == 4'(($past(op.mag) / 31'h00000064) % 31'h0000000a))
		else $error("encoded hundreds digit wrong");

	enc_top_a: assert property (en && !dec
		|=> res.mag[30:28] == 3'h0)
		else $error("encoded result has bits above seven digits");

	dir_high_a: assert property (en && ENCODE_DIRECTION_I && op.mag == 31'h00000010
		|=> res.mag == 31'h00000016)
		else $error("high direction does not encode");

	off_flag_a: assert property (!en |=> !state_ff.sat)
		else $error("saturation state kept while disabled");

	cov_dec_sat_c: cover property (en && dec && op.mag > 31'h09999999 ##1 state_ff.sat);
	cov_enc_sat_c: cover property (en && !dec && op.sign && op.mag > 31'h0098967f ##1 state_ff.sat);
	cov_enc_neg_c: cover property (en && !dec && op.sign && op.mag == 31'h0000f0e9);
	cov_disable_c: cover property (en ##1 !en ##1 res == 32'h0);
	cov_neg_zero_c: cover property (en && op.sign && op.mag == 31'h0);

endmodule

// ---- pkg/bbc_pkg.sv ----
// constants and carrier types for the decimal/binary converter
// assumes a single processing clock; no software-visible registers
package bbc_pkg;

	// ****************************************************************
	// word layout
	// ****************************************************************
	localparam int SIGN_BIT   = 31;
	localparam int MAG_W      = 31;
	localparam int DIGIT_W    = 4;
	localparam int NUM_DIGITS = 7;
	localparam int BCD_W      = NUM_DIGITS * DIGIT_W;
	localparam int BIN_W      = 24;

	// ****************************************************************
	// limits and reset values
	// ****************************************************************
	localparam logic [DIGIT_W-1:0] DIGIT_MAX  = 4'h9;
	localparam logic [MAG_W-1:0]   DEC_LIMIT  = 31'h09999999;
	localparam logic [MAG_W-1:0]   DEC_SAT    = 31'h0098967f;
	localparam logic [MAG_W-1:0]   ENC_LIMIT  = 31'h0098967f;
	localparam logic [MAG_W-1:0]   ENC_SAT    = 31'h09999999;
	localparam logic [31:0]        RESULT_RST = 32'h00000000;
	localparam logic               DIR_DECODE = 1'h0;

	typedef struct packed {
		logic             sign;
		logic [MAG_W-1:0] mag;
	} bbc_word_t;

	typedef struct packed {
		bbc_word_t result;
		logic      sat;
	} bbc_state_t;

endpackage

// ---- core/bbc_bin2bcd.sv ----
// binary magnitude to packed decimal digits, shift-and-add-three
// assumes the input is already limited to seven decimal digits
`timescale 1ns/1ps

module bbc_bin2bcd (
	input  wire logic [bbc_pkg::BIN_W-1:0] bin_i,
	output      logic [bbc_pkg::BCD_W-1:0] bcd_o
);

	// ****************************************************************
	// conversion network
	// ****************************************************************
	// purely combinational; the caller registers the result
	always_comb
	begin
		logic [bbc_pkg::BCD_W-1:0] acc;
		acc = '0;
		for (int i = bbc_pkg::BIN_W - 1; i >= 0; i--)
		begin
			for (int d = 0; d < bbc_pkg::NUM_DIGITS; d++)
			begin
				if (acc[d*bbc_pkg::DIGIT_W +: bbc_pkg::DIGIT_W] > 4'h4)
				begin
					acc[d*bbc_pkg::DIGIT_W +: bbc_pkg::DIGIT_W] =
						acc[d*bbc_pkg::DIGIT_W +: bbc_pkg::DIGIT_W] + 4'h3;
				end
			end
			acc = {acc[bbc_pkg::BCD_W-2:0], bin_i[i]};
		end
		bcd_o = acc;
	end

endmodule

// ---- tb/bbc_sink_model.sv ----
// downstream consumer model: takes the converter result at each processing edge
// assumes the result is a level straight from flip-flops
`timescale 1ns/1ps

module bbc_sink_model (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire bbc_pkg::bbc_word_t result_i,
	output      bbc_pkg::bbc_word_t seen_o
);
	// the consumer only ever reads the word at an edge, never between edges
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			seen_o <= '0;
		else
			seen_o <= result_i;
	end
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the decimal/binary converter
// assumes bbc_pkg is compiled first; one 10 MHz clock, synchronous reset
`timescale 1ns/1ps
`define CHK(got, exp) \
	begin \
		check_count++; \
		if ((got) !== (exp)) \
		begin \
			n_errors++; \
			$display("unexpected at %0t: got %h exp %h", $time, (got), (exp)); \
		end \
	end

module tb;
	logic               clk = 1'b0;
	logic               rst = 1'b1;
	logic               en  = 1'b0;
	logic               dir = 1'b0;
	bbc_pkg::bbc_word_t op  = '0;
	bbc_pkg::bbc_word_t res;
	bbc_pkg::bbc_word_t seen;
	int                 n_errors = 0;
	int                 check_count = 0;
	int                 cyc = 0;

	always #50 clk = ~clk;

	bbc_converter i_bbc_converter (.CORE_CLK_I(clk), .SYS_RST_I(rst), .CONV_ENABLE_I(en),
		.ENCODE_DIRECTION_I(dir), .CONV_OPERAND_IN_I(op), .CONV_RESULT_OUT_O(res));
	bbc_sink_model i_bbc_sink_model (.clk_i(clk), .rst_i(rst), .result_i(res), .seen_o(seen));

	// ****************************************************************
	// shared drive and check
	// ****************************************************************
	task automatic summarize();
		if (n_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// inputs land at one edge, are sampled at the next, result checked just after it
	task automatic step(input logic e, input logic d, input logic [31:0] o, input logic [31:0] x);
		@(posedge clk);
		en <= e;
		dir <= d;
		op <= o;
		@(posedge clk);
		#1;
		`CHK(res, bbc_pkg::bbc_word_t'(x))
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_reset();
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		`CHK(res, bbc_pkg::bbc_word_t'(32'h00000000))
	endtask

	task automatic t_decode();
		step(1'b1, 1'b0, 32'h00000009, 32'h00000009);
		step(1'b1, 1'b0, 32'h0000000e, 32'h00000009);
		step(1'b1, 1'b0, 32'h00000013, 32'h0000000d);
		step(1'b1, 1'b0, 32'h00000010, 32'h0000000a);
		step(1'b1, 1'b0, 32'h0000f0e9, 32'h0000238b);
		step(1'b1, 1'b0, 32'h8000f0e9, 32'h8000238b);
		step(1'b1, 1'b0, 32'h80000000, 32'h80000000);
		step(1'b1, 1'b0, 32'h09999999, 32'h0098967f);
		step(1'b1, 1'b0, 32'h0999999a, 32'h0098967f);
		step(1'b1, 1'b0, 32'h7fffffff, 32'h0098967f);
		step(1'b1, 1'b0, 32'h8999999a, 32'h8098967f);
		step(1'b1, 1'b0, 32'hffffffff, 32'h8098967f);
	endtask

	task automatic t_encode();
		step(1'b1, 1'b1, 32'h00000007, 32'h00000007);
		step(1'b1, 1'b1, 32'h0000000b, 32'h00000011);
		step(1'b1, 1'b1, 32'h00000013, 32'h00000019);
		step(1'b1, 1'b1, 32'h00000010, 32'h00000016);
		step(1'b1, 1'b1, 32'h8000f0e9, 32'h80061673);
		step(1'b1, 1'b1, 32'h0098967f, 32'h09999999);
		step(1'b1, 1'b1, 32'h00989680, 32'h09999999);
		step(1'b1, 1'b1, 32'h7fffffff, 32'h09999999);
		step(1'b1, 1'b1, 32'h80989680, 32'h89999999);
		step(1'b1, 1'b1, 32'h8098967f, 32'h89999999);
	endtask

	// direction flips while the operand stays, so a stale result shows at once
	task automatic t_switch();
		step(1'b1, 1'b0, 32'h00000013, 32'h0000000d);
		step(1'b1, 1'b1, 32'h00000013, 32'h00000019);
		step(1'b1, 1'b0, 32'h00000013, 32'h0000000d);
	endtask

	task automatic t_disable();
		step(1'b0, 1'b1, 32'h00000013, 32'h00000000);
		step(1'b0, 1'b0, 32'h8000f0e9, 32'h00000000);
		@(posedge clk);
		#1;
		`CHK(seen, bbc_pkg::bbc_word_t'(32'h00000000))
		step(1'b1, 1'b0, 32'h8000f0e9, 32'h8000238b);
	endtask

	// ****************************************************************
	// run and hang guard
	// ****************************************************************
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 500)
		begin
			n_errors++;
			summarize();
		end
	end

	initial
	begin
		t_reset();
		t_decode();
		t_encode();
		t_switch();
		t_disable();
		summarize();
	end
endmodule
